// ===== verilog/cst_top.sv
// calibration status flags, status pin selector and trigger source control
//
// Overview of operation
// - With background calibration on, the stopped flag is 1 while it is halted at its phase, else 0.
// - With background calibration off, the stopped flag sets once foreground ends or is skipped.
// - Bit 0 of the state flag register goes high when foreground calibration completes.
// - Status pin code 0 follows foreground done, 2 the alarm, 3 holds low; code 1 is reserved.
// - Source 1 takes the trigger from the external pin, source 0 from the software bit.
// - The software bit stands in for the external trigger pin only while software is selected.
// - After reset the pin configuration reads 0x00 and the software trigger register reads 0x01.
// - Background calibration runs only with its enable set, off at reset; it picks the flag rule.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/10ps
module cst_top
  import cst_pkg::*;
#(
  parameter int unsigned ADR_W = 12
) (
  input  wire logic                  CORE_CLK,
  input  wire logic                  RST,
  // classic wishbone slave
  input  wire logic                  WB_CYC_I,
  input  wire logic                  WB_STB_I,
  input  wire logic                  WB_WE_I,
  input  wire logic [ADR_W-1:0]      WB_ADR_I,
  input  wire logic [3:0]            WB_SEL_I,
  input  wire logic [31:0]           WB_DAT_I,
  output logic      [31:0]           WB_DAT_O,
  output logic                       WB_ACK_O,
  // calibration engine
  input  wire cst_pkg::cst_engine_type  CAL_ENGINE,
  output cst_pkg::cst_control_type      CAL_CONTROL,
  // pins
  input  wire logic                  EXTERNAL_TRIGGER_INPUT,
  output logic                       CALIBRATION_STATE_PIN
);
  import cst_pkg::*;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } cst_bus_type;

  cst_bus_type  bus_q;
  logic [7:0]   cal_config_q;
  logic [7:0]   pin_config_q;
  logic [7:0]   soft_trigger_q;
  logic [7:0]   low_power_q;
  logic         foreground_complete_flag_q;
  logic         bg_stopped_q;
  logic         bg_stopped_d;
  logic         trigger_q;
  logic         trigger_d;
  logic         state_pin_q;
  logic         state_pin_d;
  logic         ext_trigger_sync;
  logic [31:0]  rd_data_q;
  logic         bus_req;
  logic         wr_fire;
  logic [IDX_W-1:0] req_idx;
  cst_sel_type  status_sel;

  function automatic logic [7:0] masked_write(input logic [7:0] old_val,
                                               input logic [7:0] new_val,
                                               input logic [7:0] mask);
    masked_write = (old_val & ~mask) | (new_val & mask);
  endfunction : masked_write

  function automatic logic [IDX_W-1:0] word_index(input logic [ADR_W-1:0] adr);
    word_index = adr[IDX_W+1:2];
  endfunction : word_index

  cst_sync2 u_trig_sync (
    .CORE_CLK (CORE_CLK),
    .RST      (RST),
    .async_in (EXTERNAL_TRIGGER_INPUT),
    .sync_out (ext_trigger_sync)
  );

  // ---------------- wishbone slave ----------------
  assign bus_req = WB_CYC_I & WB_STB_I;
  assign req_idx = word_index(WB_ADR_I);
  // a write lands on the edge at which the master samples ack
  assign wr_fire = (bus_q == BUS_ACK) & bus_req & WB_WE_I & WB_SEL_I[0];

  // ack one cycle after the request is seen, dropped the cycle after
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      bus_q <= BUS_IDLE;
    end else begin
      unique case (bus_q)
        BUS_IDLE: bus_q <= bus_req ? BUS_ACK : BUS_IDLE;
        BUS_ACK:  bus_q <= BUS_IDLE;
        default:  bus_q <= BUS_IDLE;
      endcase
    end
  end

  assign WB_ACK_O = (bus_q == BUS_ACK);

  // read data captured with the request; unmapped indices read zero
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rd_data_q <= 32'h0000_0000;
    end else if (bus_q == BUS_IDLE && bus_req) begin
      unique case (req_idx)
        IDX_CAL_CONFIG:   rd_data_q <= {24'h00_0000, cal_config_q};
        IDX_STATE_FLAGS:  rd_data_q <= {30'h0, bg_stopped_q, foreground_complete_flag_q};
        IDX_PIN_CONFIG:   rd_data_q <= {24'h00_0000, pin_config_q};
        IDX_SOFT_TRIGGER: rd_data_q <= {24'h00_0000, soft_trigger_q};
        IDX_LOW_POWER_BG: rd_data_q <= {24'h00_0000, low_power_q};
        default:          rd_data_q <= 32'h0000_0000;
      endcase
    end
  end

  assign WB_DAT_O = rd_data_q;

  // ---------------- writable registers ----------------
  // the flag register has no write path at all
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cal_config_q   <= RST_CAL_CONFIG;
      pin_config_q   <= RST_PIN_CONFIG;
      soft_trigger_q <= RST_SOFT_TRIGGER;
      low_power_q    <= RST_LOW_POWER_BG;
    end else if (wr_fire) begin
      unique case (req_idx)
        IDX_CAL_CONFIG:
          cal_config_q <= masked_write(cal_config_q, WB_DAT_I[7:0], MASK_CAL_CONFIG);
        IDX_PIN_CONFIG:
          pin_config_q <= masked_write(pin_config_q, WB_DAT_I[7:0], MASK_PIN_CONFIG);
        IDX_SOFT_TRIGGER:
          soft_trigger_q <= masked_write(soft_trigger_q, WB_DAT_I[7:0], MASK_SOFT_TRIG);
        IDX_LOW_POWER_BG:
          low_power_q <= masked_write(low_power_q, WB_DAT_I[7:0], MASK_LOW_POWER);
        default: ;
      endcase
    end
  end

  // ---------------- status flags ----------------
  // completion wins over a restart in the same cycle so no event is lost
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      foreground_complete_flag_q <= 1'b0;
    end else if (CAL_ENGINE.fg_complete) begin
      foreground_complete_flag_q <= 1'b1;
    end else if (CAL_ENGINE.fg_restart) begin
      foreground_complete_flag_q <= 1'b0;
    end
  end

  // a cleared foreground run bit counts as a skipped foreground pass
  always_comb begin
    if (cal_config_q[POS_BG_ENABLE]) begin
      bg_stopped_d = CAL_ENGINE.bg_halted;
    end else begin
      bg_stopped_d = foreground_complete_flag_q | ~cal_config_q[POS_FG_RUN];
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      bg_stopped_q <= 1'b0;
    end else begin
      bg_stopped_q <= bg_stopped_d;
    end
  end

  // ---------------- trigger source ----------------
  always_comb begin
    if (pin_config_q[POS_TRIG_SOURCE]) begin
      trigger_d = ext_trigger_sync;
    end else begin
      trigger_d = soft_trigger_q[POS_SOFT_TRIG];
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      trigger_q <= 1'b0;
    end else begin
      trigger_q <= trigger_d;
    end
  end

  // one driver for the whole carrier, so no field can be left floating
  assign CAL_CONTROL = '{trigger:   trigger_q,
                         bg_enable: cal_config_q[POS_BG_ENABLE],
                         fg_run:    cal_config_q[POS_FG_RUN],
                         low_power: low_power_q};

  // ---------------- status pin ----------------
  assign status_sel = cst_sel_type'(pin_config_q[POS_STATUS_SEL +: 2]);

  // the reserved code drives low, the quietest choice
  always_comb begin
    unique case (status_sel)
      SEL_FOREGROUND_COMPLETE_FLAG:  state_pin_d = foreground_complete_flag_q;
      SEL_ALARM:    state_pin_d = CAL_ENGINE.alarm;
      SEL_LOW:      state_pin_d = 1'b0;
      SEL_RESERVED: state_pin_d = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_pin_q <= 1'b0;
    end else begin
      state_pin_q <= state_pin_d;
    end
  end

  assign CALIBRATION_STATE_PIN = state_pin_q;

  // ---------------- assertions ----------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  logic rst_seen_q;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rst_seen_q <= 1'b0;
    end else begin
      rst_seen_q <= 1'b1;
    end
  end

  bg_halt_flag_a: assert property (
    cal_config_q[POS_BG_ENABLE] && CAL_ENGINE.bg_halted |=> bg_stopped_q)
    else $error("stopped flag not set after background halt");

  bg_resume_flag_a: assert property (
    cal_config_q[POS_BG_ENABLE] && !CAL_ENGINE.bg_halted |=> !bg_stopped_q)
    else $error("stopped flag not cleared when background runs");

  fg_stop_flag_a: assert property (
    !cal_config_q[POS_BG_ENABLE] && foreground_complete_flag_q |=> bg_stopped_q)
    else $error("stopped flag not set after foreground end");

  foreground_complete_flag_set_a: assert property (
    CAL_ENGINE.fg_complete |=> foreground_complete_flag_q && rd_data_q[31:2] == 30'h0 ##1 foreground_complete_flag_q
      || CAL_ENGINE.fg_restart)
    else $error("foreground done flag not set");

  pin_select_a: assert property (
    status_sel == SEL_ALARM |=> CALIBRATION_STATE_PIN == $past(CAL_ENGINE.alarm))
    else $error("status pin does not follow alarm");

  pin_low_a: assert property (
    status_sel == SEL_LOW && $past(status_sel == SEL_LOW) |-> !CALIBRATION_STATE_PIN)
    else $error("status pin not held low");

  pin_fg_a: assert property (
    status_sel == SEL_FOREGROUND_COMPLETE_FLAG |=> CALIBRATION_STATE_PIN == $past(foreground_complete_flag_q))
    else $error("status pin does not follow foreground done");

  ext_trigger_a: assert property (
    pin_config_q[POS_TRIG_SOURCE] |=> trigger_q == $past(ext_trigger_sync))
    else $error("trigger not taken from the external pin");

  soft_trigger_a: assert property (
    !pin_config_q[POS_TRIG_SOURCE] |=> trigger_q == $past(soft_trigger_q[POS_SOFT_TRIG]))
    else $error("trigger not taken from the software bit");

  reset_value_a: assert property (
    $rose(rst_seen_q) |-> pin_config_q == RST_PIN_CONFIG
      && soft_trigger_q == RST_SOFT_TRIGGER && !cal_config_q[POS_BG_ENABLE])
    else $error("reset values wrong");

  flag_read_a: assert property (
    bus_q == BUS_IDLE && bus_req && req_idx == IDX_STATE_FLAGS
      |=> WB_ACK_O && WB_DAT_O[31:2] == 30'h0)
    else $error("state flag read shows reserved bits or no ack");

  ack_one_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held for more than one cycle");

  ack_latency_a: assert property (bus_q == BUS_IDLE && bus_req |=> WB_ACK_O)
    else $error("ack not given one cycle after a request");

  flag_write_a: assert property (
    wr_fire && req_idx == IDX_STATE_FLAGS |=> $stable(cal_config_q) && $stable(pin_config_q)
      && $stable(soft_trigger_q) && $stable(low_power_q))
    else $error("write to the state flag register changed a register");

  pin_reserved_a: assert property (
    status_sel == SEL_RESERVED |=> !CALIBRATION_STATE_PIN)
    else $error("status pin not low for the reserved code");

  fg_restart_a: assert property (
    CAL_ENGINE.fg_restart && !CAL_ENGINE.fg_complete |=> !foreground_complete_flag_q)
    else $error("foreground done flag not cleared by restart");

  skip_flag_a: assert property (
    !cal_config_q[POS_BG_ENABLE] && !cal_config_q[POS_FG_RUN] |=> bg_stopped_q)
    else $error("stopped flag not set when foreground is skipped");

  cover_foreground_complete_flag_c:   cover property (CAL_ENGINE.fg_complete ##1 foreground_complete_flag_q);
  cover_bg_stop_c:   cover property (cal_config_q[POS_BG_ENABLE] ##1 bg_stopped_q);
  cover_ext_trig_c:  cover property (pin_config_q[POS_TRIG_SOURCE] && $rose(trigger_q));
  cover_alarm_pin_c: cover property (status_sel == SEL_ALARM && CALIBRATION_STATE_PIN);
  cover_skip_c:      cover property (!cal_config_q[POS_FG_RUN] ##1 bg_stopped_q);

endmodule : cst_top

// ===== verilog/cst_pkg.sv
// constants and carrier types for the calibration status and trigger block
package cst_pkg;

  localparam int unsigned IDX_W = 10;

  // register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CAL_CONFIG   = 10'h062;
  localparam logic [IDX_W-1:0] IDX_STATE_FLAGS  = 10'h06a;
  localparam logic [IDX_W-1:0] IDX_PIN_CONFIG   = 10'h06b;
  localparam logic [IDX_W-1:0] IDX_SOFT_TRIGGER = 10'h06c;
  localparam logic [IDX_W-1:0] IDX_LOW_POWER_BG = 10'h06e;

  // reset values
  localparam logic [7:0] RST_CAL_CONFIG   = 8'h01;
  localparam logic [7:0] RST_PIN_CONFIG   = 8'h00;
  localparam logic [7:0] RST_SOFT_TRIGGER = 8'h01;
  localparam logic [7:0] RST_LOW_POWER_BG = 8'h88;

  // field positions
  localparam int unsigned POS_FG_RUN      = 0;
  localparam int unsigned POS_BG_ENABLE   = 1;
  localparam int unsigned POS_FOREGROUND_COMPLETE_FLAG     = 0;
  localparam int unsigned POS_BG_STOPPED  = 1;
  localparam int unsigned POS_TRIG_SOURCE = 0;
  localparam int unsigned POS_STATUS_SEL  = 1;
  localparam int unsigned POS_SOFT_TRIG   = 0;

  // writable bit masks; reserved bits of the flag register read zero
  localparam logic [7:0] MASK_CAL_CONFIG  = 8'h1f;
  localparam logic [7:0] MASK_PIN_CONFIG  = 8'h07;
  localparam logic [7:0] MASK_SOFT_TRIG   = 8'h01;
  localparam logic [7:0] MASK_LOW_POWER   = 8'hfb;

  // status pin selector codes
  typedef enum logic [1:0] {
    SEL_FOREGROUND_COMPLETE_FLAG  = 2'h0,
    SEL_RESERVED = 2'h1,
    SEL_ALARM    = 2'h2,
    SEL_LOW      = 2'h3
  } cst_sel_type;

  // events and levels from the calibration engine, same clock
  typedef struct packed {
    logic fg_complete;  // one-cycle pulse: foreground calibration finished
    logic fg_restart;   // one-cycle pulse: calibration restarts
    logic bg_halted;    // level: background halted at requested phase
    logic alarm;        // level: alarm condition
  } cst_engine_type;

  // controls handed to the calibration engine
  typedef struct packed {
    logic trigger;      // selected calibration trigger level
    logic bg_enable;    // background calibration may run
    logic fg_run;       // foreground calibration requested
    logic [7:0] low_power;
  } cst_control_type;

endpackage : cst_pkg

// ===== verilog/cst_sync2.sv
// two-flop synchroniser for a level arriving from a pin
`timescale 1ns/10ps
module cst_sync2 (
  input  wire logic CORE_CLK,
  input  wire logic RST,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;

  // meta_q is read by sync_out only
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : cst_sync2

// ===== tb/tb_top.sv
// self-checking testbench for the calibration status and trigger block
`timescale 1ns/10ps
module tb_top;
  import cst_pkg::*;

  typedef struct packed {
    logic [9:0] idx;
    logic [7:0] wr;
    logic [7:0] exp;
  } cst_row_type;

  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            cyc = 1'b0;
  logic            stb = 1'b0;
  logic            we  = 1'b0;
  logic [11:0]     adr = 12'h000;
  logic [3:0]      sel = 4'h0;
  logic [31:0]     dat = 32'h0;
  logic [31:0]     dat_o;
  logic            ack;
  cst_engine_type  eng = '0;
  cst_control_type ctl;
  logic            ext = 1'b0;
  logic            pin;
  logic [31:0]     rd;
  int              miscompares = 0;
  int              tests_run = 0;
  // write each row, read it back; 0x3ff is an unmapped index
  cst_row_type     rows [6] = '{'{10'h06b, 8'hff, 8'h07}, '{10'h06c, 8'hfe, 8'h00},
                                '{10'h06e, 8'hff, 8'hfb}, '{10'h06a, 8'hff, 8'h00},
                                '{10'h3ff, 8'hff, 8'h00}, '{10'h062, 8'hff, 8'h1f}};

  always #5 clk = ~clk;

  cst_top cst_top_i (
    .CORE_CLK               (clk),
    .RST                    (rst),
    .WB_CYC_I               (cyc),
    .WB_STB_I               (stb),
    .WB_WE_I                (we),
    .WB_ADR_I               (adr),
    .WB_SEL_I               (sel),
    .WB_DAT_I               (dat),
    .WB_DAT_O               (dat_o),
    .WB_ACK_O               (ack),
    .CAL_ENGINE             (eng),
    .CAL_CONTROL            (ctl),
    .EXTERNAL_TRIGGER_INPUT (ext),
    .CALIBRATION_STATE_PIN  (pin)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp, input string what);
    chk({31'h0, got}, {31'h0, exp}, what);
  endtask : chk1

  // master waits for ack as long as it takes; only the watchdog ends a hung wait
  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    sel <= 4'hf;
    dat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    chk(n, 32'd2, "bus ack latency");
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rdchk(input logic [9:0] idx, input logic [7:0] e, input string what);
    wb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, e}, what);
  endtask : rdchk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic pulse(input logic restart);
    @(posedge clk);
    eng.fg_complete <= ~restart;
    eng.fg_restart  <= restart;
    @(posedge clk);
    eng.fg_complete <= 1'b0;
    eng.fg_restart  <= 1'b0;
  endtask : pulse

  task automatic test_end(input string name);
    $display("test %s finished", name);
  endtask : test_end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdchk(IDX_PIN_CONFIG, 8'h00, "pin config reset");
    rdchk(IDX_SOFT_TRIGGER, 8'h01, "soft trigger reset");
    rdchk(IDX_CAL_CONFIG, 8'h01, "cal config reset");
    rdchk(IDX_LOW_POWER_BG, 8'h88, "low power reset");
    chk1(ctl.trigger, 1'b1, "idle trigger high");
    chk1(ctl.bg_enable, 1'b0, "background off");
    chk1(ctl.fg_run, 1'b1, "foreground run reset");
    chk({24'h0, ctl.low_power}, 32'h88, "low power out reset");
    test_end("reset");
    foreach (rows[i]) begin
      wb(1'b1, rows[i].idx, rows[i].wr);
      rdchk(rows[i].idx, rows[i].exp, "register row");
    end
    chk({24'h0, ctl.low_power}, 32'hfb, "low power out");
    wb(1'b1, IDX_PIN_CONFIG, 8'h00);
    wb(1'b1, IDX_SOFT_TRIGGER, 8'h01);
    wb(1'b1, IDX_CAL_CONFIG, 8'h01);
    test_end("registers");
    rdchk(IDX_STATE_FLAGS, 8'h00, "flags idle");
    pulse(1'b0);
    tick(3);
    chk1(pin, 1'b1, "pin follows done");
    rdchk(IDX_STATE_FLAGS, 8'h03, "foreground_complete_flag");
    wb(1'b1, IDX_STATE_FLAGS, 8'h00);
    rdchk(IDX_STATE_FLAGS, 8'h03, "flags write ignored");
    pulse(1'b1);
    rdchk(IDX_STATE_FLAGS, 8'h00, "restart clears");
    wb(1'b1, IDX_CAL_CONFIG, 8'h00);
    rdchk(IDX_STATE_FLAGS, 8'h02, "fg skipped");
    chk1(ctl.fg_run, 1'b0, "foreground skipped out");
    wb(1'b1, IDX_CAL_CONFIG, 8'h03);
    tick(1);
    chk1(ctl.bg_enable, 1'b1, "background on");
    rdchk(IDX_STATE_FLAGS, 8'h00, "bg running");
    @(posedge clk);
    eng.bg_halted <= 1'b1;
    rdchk(IDX_STATE_FLAGS, 8'h02, "bg halted");
    @(posedge clk);
    eng.bg_halted <= 1'b0;
    rdchk(IDX_STATE_FLAGS, 8'h00, "bg resumed");
    test_end("flags");
    pulse(1'b0);
    for (int a = 0; a < 2; a++) begin
      for (int s = 0; s < 4; s++) begin
        @(posedge clk);
        eng.alarm <= a[0];
        wb(1'b1, IDX_PIN_CONFIG, {5'h0, s[1:0], 1'b0});
        tick(3);
        chk1(pin, (s == 0) || (s == 2 && a == 1), "status pin select");
      end
    end
    test_end("selector");
    wb(1'b1, IDX_PIN_CONFIG, 8'h00);
    wb(1'b1, IDX_SOFT_TRIGGER, 8'h00);
    @(posedge clk);
    ext <= 1'b1;
    tick(5);
    chk1(ctl.trigger, 1'b0, "pin ignored");
    wb(1'b1, IDX_PIN_CONFIG, 8'h01);
    tick(5);
    chk1(ctl.trigger, 1'b1, "pin selected");
    @(posedge clk);
    ext <= 1'b0;
    tick(5);
    chk1(ctl.trigger, 1'b0, "pin low");
    wb(1'b1, IDX_SOFT_TRIGGER, 8'h01);
    tick(2);
    chk1(ctl.trigger, 1'b0, "soft ignored");
    wb(1'b1, IDX_PIN_CONFIG, 8'h00);
    tick(2);
    chk1(ctl.trigger, 1'b1, "soft selected");
    test_end("trigger");
    wb(1'b1, IDX_PIN_CONFIG, 8'h05);
    wb(1'b1, IDX_SOFT_TRIGGER, 8'h00);
    @(posedge clk);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    rdchk(IDX_PIN_CONFIG, 8'h00, "pin config after reset");
    rdchk(IDX_SOFT_TRIGGER, 8'h01, "soft trigger after reset");
    test_end("second reset");
    close_out();
  end

  // whole run needs about two hundred cycles; this span is far beyond it
  initial begin
    #200000;
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end
endmodule : tb_top
